// ---- rtl/cre_ctrl_endian_align.sv ----
// Control registers, loop state flags, byte order and alignment checking.
`timescale 1ns/10ps
// ***********************************************************************
// Overview of operation
// - Four scratch registers never affect processor behaviour.
// - Scratch registers readable always, writable only supervisor.
// - Concurrency config writable supervisor only, readable always.
// - Two mode bits select external, internal, reserved.
// - Internal mode redirects two-page window to loop unit.
// - Loop iteration register is a 32-bit counter.
// - In-loop flag set on non-nested start, cleared on serial unless nested and not idle.
// - Nested start copies in-loop into nesting flag.
// - Detached flag always mirrors the internal-only bit.
// - Address sums wrap modulo two to the 32.
// - Little-endian default, big-endian when selected by supervisor.
// - Instruction fetch is always little-endian.
// - Page directory and table reads are little-endian.
// - Byte order also applies to I/O cycles.
// - Misaligned data or I/O reference raises a data-access trap.
// - 128-bit operands need four low address bits zero.
// - 64-bit operands need three low address bits zero.
// - 32-bit needs two, 16-bit needs one zero bit.
// - Privilege level taken from status register user bit.
// - User-level stores to protected registers are ignored.
// ***********************************************************************
module cre_ctrl_endian_align #(
   parameter int ITER_WIDTH = 32
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic status_user_level,
   input wire logic big_endian_select,
   input wire logic control_reg_load,
   input wire logic control_reg_store,
   input wire logic [3:0] ctrl_sel,
   input wire logic [31:0] ctrl_wdata,
   output logic [31:0] ctrl_rdata,
   input wire logic loop_start,
   input wire logic loop_start_nested,
   input wire logic loop_to_serial,
   input wire logic loop_idle,
   input wire logic iter_advance,
   input wire cre_pkg::cre_mem_req_s mem_req,
   output cre_pkg::cre_mem_out_s mem_out,
   output logic [63:0] load_swap_mask
);
   // Elaboration check: the counter has exactly the documented width.
   if (ITER_WIDTH != 32) begin : g_bad_width
      $error("ITER_WIDTH must be 32");
   end

   // ********************************************************************
   // Register storage.
   // ********************************************************************
   // Scratch words for system software; nothing else reads them.
   logic [31:0] scratch_r [4];
   logic [31:0] ccfg_r; // Concurrency configuration word.
   logic [ITER_WIDTH-1:0] iter_r; // Loop iteration counter.
   logic in_loop_r; // Processor is inside a concurrent loop.
   logic nested_r; // Processor is in the nested state.
   cre_pkg::cre_mem_out_s mem_out_r; // Registered memory reference.
   logic [63:0] swap_r; // Registered byte-lane order hint.

   // ********************************************************************
   // Access decode.
   // ********************************************************************
   // Supervisor level is the clear user bit of the status register.
   wire supervisor = ~status_user_level;
   // Privileged stores from user level are dropped silently.
   wire priv_store = control_reg_store & supervisor;
   wire wr_scratch = priv_store & (ctrl_sel[3:2] == 2'b00);
   wire wr_ccfg = priv_store & (ctrl_sel == cre_pkg::SEL_CONCURRENCY_CONFIG);
   // The loop-unit registers are not protected and take user stores too.
   wire wr_iter = control_reg_store & (ctrl_sel == cre_pkg::SEL_LOOP_ITERATION_COUNT);
   wire wr_flags = control_reg_store & (ctrl_sel == cre_pkg::SEL_LOOP_CONDITION_FLAGS);
   wire unit_on = ccfg_r[cre_pkg::CCFG_UNIT_ON_BIT];
   wire detached_only = ccfg_r[cre_pkg::CCFG_DETACHED_ONLY_BIT];
   // Mode decode looks at both bits together; mixed values are reserved.
   wire cre_pkg::cre_mode_e mode = (unit_on & detached_only) ? cre_pkg::CRE_MODE_INTERNAL :
      (~unit_on & ~detached_only) ? cre_pkg::CRE_MODE_EXTERNAL :
      cre_pkg::CRE_MODE_RESERVED;
   // Flags word: detached bit follows the configuration live.
   wire [31:0] flags_word = {29'h0000_0000, detached_only, nested_r, in_loop_r};

   // Read mux is a plain if chain; scratch contents only ever reach here.
   logic [31:0] rdata_mux;
   always_comb begin
      rdata_mux = cre_pkg::RST_WORD;
      if (ctrl_sel[3:2] == 2'b00) begin
         rdata_mux = scratch_r[ctrl_sel[1:0]];
      end else if (ctrl_sel == cre_pkg::SEL_CONCURRENCY_CONFIG) begin
         rdata_mux = ccfg_r;
      end else if (ctrl_sel == cre_pkg::SEL_LOOP_ITERATION_COUNT) begin
         rdata_mux = iter_r;
      end else if (ctrl_sel == cre_pkg::SEL_LOOP_CONDITION_FLAGS) begin
         rdata_mux = flags_word;
      end
   end
   // Reads are combinational so a load sees the value in the same cycle.
   assign ctrl_rdata = control_reg_load ? rdata_mux : cre_pkg::RST_WORD;

   // ********************************************************************
   // Scratch and configuration registers.
   // ********************************************************************
   // Each scratch word updates only on its own supervisor store.
   for (genvar g = 0; g < 4; g++) begin : g_scratch
      always_ff @(posedge core_clk or negedge arst_n) begin
         if (!arst_n) begin
            scratch_r[g] <= cre_pkg::RST_WORD;
         end else if (wr_scratch && ctrl_sel[1:0] == 2'(g)) begin
            scratch_r[g] <= ctrl_wdata;
         end
      end
   end

   // Configuration word; reset leaves external or no loop unit.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ccfg_r <= cre_pkg::RST_WORD;
      end else if (wr_ccfg) begin
         ccfg_r <= ctrl_wdata;
      end
   end

   // ********************************************************************
   // Loop unit state.
   // ********************************************************************
   // Iteration counter: a store wins, else the loop unit steps it.
   // Wrapping beyond 32 bits is harmless since the upper half is absent.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         iter_r <= '0;
      end else if (wr_iter) begin
         iter_r <= ctrl_wdata;
      end else if (iter_advance) begin
         iter_r <= iter_r + 1'b1;
      end
   end

   // Loop flags: hardware events take priority over a direct write,
   // so a loop start in the same cycle as a store is not lost.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         in_loop_r <= 1'b0;
         nested_r <= 1'b0;
      end else begin
         if (loop_start && !loop_start_nested) begin
            in_loop_r <= 1'b1;
         end else if (loop_to_serial && (!nested_r || loop_idle)) begin
            in_loop_r <= 1'b0;
         end else if (wr_flags) begin
            in_loop_r <= ctrl_wdata[cre_pkg::FLAG_IN_LOOP_BIT];
         end
         if (loop_start && loop_start_nested) begin
            nested_r <= in_loop_r;
         end else if (wr_flags) begin
            nested_r <= ctrl_wdata[cre_pkg::FLAG_NESTED_BIT];
         end
      end
   end

   // ********************************************************************
   // Address handling.
   // ********************************************************************
   // Sum truncated to 32 bits; the carry out is dropped on purpose.
   wire [31:0] eff_addr = 32'(mem_req.base + mem_req.offset);

   // Alignment mask per operand size, used once below by the misalign check.
   function automatic logic [3:0] align_mask(input cre_pkg::cre_size_e sz);
      case (sz)
         cre_pkg::CRE_SZ_128: align_mask = 4'hf;
         cre_pkg::CRE_SZ_64: align_mask = 4'h7;
         cre_pkg::CRE_SZ_32: align_mask = 4'h3;
         cre_pkg::CRE_SZ_16: align_mask = 4'h1;
         default: align_mask = 4'h0;
      endcase
   endfunction

   wire misaligned = |(eff_addr[3:0] & align_mask(mem_req.size));
   // Only data-side references are subject to the data-access trap.
   wire is_data = (mem_req.kind == cre_pkg::CRE_ACC_DATA) ||
      (mem_req.kind == cre_pkg::CRE_ACC_IO);
   wire data_trap = mem_req.valid & is_data & misaligned;
   // Window match compares all bits above the two-page span.
   wire in_window = eff_addr[31:cre_pkg::WINDOW_LSB] ==
      ccfg_r[31:cre_pkg::CCFG_BASE_LSB];
   wire to_unit = (mode == cre_pkg::CRE_MODE_INTERNAL) & (mem_req.kind == cre_pkg::CRE_ACC_DATA)
      & in_window & ~data_trap;
   // Fetches and page walks ignore the byte-order select.
   wire use_big = big_endian_select & is_data;

   // Byte-lane mask: XOR of the lane index for big-endian, by size.
   wire [2:0] lane_flip = (mem_req.size == cre_pkg::CRE_SZ_8) ? 3'h0 :
      (mem_req.size == cre_pkg::CRE_SZ_16) ? 3'h1 :
      (mem_req.size == cre_pkg::CRE_SZ_32) ? 3'h3 : 3'h7;
   logic [63:0] swap_nxt;
   always_comb begin
      swap_nxt = '0;
      for (int i = 0; i < 8; i++) begin
         swap_nxt[i*8 +: 8] = use_big ? {5'h00, 3'(i) ^ lane_flip} : {5'h00, 3'(i)};
      end
   end

   // Result of the reference is registered, one cycle after the request.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_out_r <= '0;
         swap_r <= '0;
      end else begin
         mem_out_r.valid <= mem_req.valid;
         mem_out_r.addr <= eff_addr;
         mem_out_r.to_loop_unit <= mem_req.valid & to_unit;
         mem_out_r.trap <= data_trap;
         mem_out_r.wdata <= mem_req.wdata;
         swap_r <= swap_nxt;
      end
   end
   assign mem_out = mem_out_r;
   assign load_swap_mask = swap_r;

   // ********************************************************************
   // Checks.
   // ********************************************************************
   property p_user_scratch;
      @(posedge core_clk) disable iff (!arst_n)
      (control_reg_store && status_user_level && ctrl_sel == 4'h0) |=> $stable(scratch_r[0]);
   endproperty
   a_user_scratch: assert property (p_user_scratch) else $error("user wrote scratch");
   property p_user_ccfg;
      @(posedge core_clk) disable iff (!arst_n)
      (control_reg_store && status_user_level) |=> $stable(ccfg_r);
   endproperty
   a_user_ccfg: assert property (p_user_ccfg) else $error("user wrote config");
   // Judged at the read port, so a broken read path is caught as well.
   property p_detached;
      @(posedge core_clk) disable iff (!arst_n)
      (control_reg_load && ctrl_sel == cre_pkg::SEL_LOOP_CONDITION_FLAGS) |->
         ctrl_rdata[cre_pkg::FLAG_DETACHED_BIT] == ccfg_r[cre_pkg::CCFG_DETACHED_ONLY_BIT];
   endproperty
   a_detached: assert property (p_detached) else $error("detached flag mismatch");
   property p_loop_set;
      @(posedge core_clk) disable iff (!arst_n)
      (loop_start && !loop_start_nested) |=> in_loop_r;
   endproperty
   a_loop_set: assert property (p_loop_set) else $error("in-loop not set");
   property p_nested_copy;
      @(posedge core_clk) disable iff (!arst_n)
      (loop_start && loop_start_nested) |=> nested_r == $past(in_loop_r);
   endproperty
   a_nested_copy: assert property (p_nested_copy) else $error("nested copy wrong");
   property p_trap_128;
      @(posedge core_clk) disable iff (!arst_n)
      (mem_req.valid && is_data && mem_req.size == cre_pkg::CRE_SZ_128 && eff_addr[3:0] != 4'h0)
      |=> mem_out.trap;
   endproperty
   a_trap_128: assert property (p_trap_128) else $error("128-bit misalign missed");
   property p_trap_32;
      @(posedge core_clk) disable iff (!arst_n)
      (mem_req.valid && is_data && mem_req.size == cre_pkg::CRE_SZ_32)
      |=> mem_out.trap == ($past(eff_addr[1:0]) != 2'b00);
   endproperty
   a_trap_32: assert property (p_trap_32) else $error("32-bit alignment wrong");
   property p_fetch_little;
      @(posedge core_clk) disable iff (!arst_n)
      (mem_req.kind == cre_pkg::CRE_ACC_FETCH) |=> load_swap_mask[15:8] == 8'h01;
   endproperty
   a_fetch_little: assert property (p_fetch_little) else $error("fetch not little");
   property p_wrap;
      @(posedge core_clk) disable iff (!arst_n)
      mem_req.valid |=> mem_out.addr == 32'($past(mem_req.base) + $past(mem_req.offset));
   endproperty
   a_wrap: assert property (p_wrap) else $error("address sum wrong");
endmodule // cre_ctrl_endian_align

// ---- include/cre_pkg.sv ----
// Package for the control-register, byte-order and alignment block.
package cre_pkg;
   // ********************************************************************
   // Control register selectors (index on the control-register port).
   // ********************************************************************
   localparam logic [3:0] SEL_OS_SCRATCH_0 = 4'h0;
   localparam logic [3:0] SEL_OS_SCRATCH_1 = 4'h1;
   localparam logic [3:0] SEL_OS_SCRATCH_2 = 4'h2;
   localparam logic [3:0] SEL_OS_SCRATCH_3 = 4'h3;
   localparam logic [3:0] SEL_CONCURRENCY_CONFIG = 4'h4;
   localparam logic [3:0] SEL_LOOP_ITERATION_COUNT = 4'h5;
   localparam logic [3:0] SEL_LOOP_CONDITION_FLAGS = 4'h6;
   // ********************************************************************
   // Field positions inside the concurrency configuration register.
   // ********************************************************************
   localparam int CCFG_UNIT_ON_BIT = 0;
   localparam int CCFG_DETACHED_ONLY_BIT = 1;
   localparam int CCFG_BASE_LSB = 13;
   // Field positions inside the loop condition flags register.
   localparam int FLAG_IN_LOOP_BIT = 0;
   localparam int FLAG_NESTED_BIT = 1;
   localparam int FLAG_DETACHED_BIT = 2;
   // Window spans two pages: bits above this are compared with the base.
   localparam int WINDOW_LSB = 13;
   // ********************************************************************
   // Values after reset.
   // ********************************************************************
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // Operand sizes of a memory reference.
   typedef enum logic [2:0] {
      CRE_SZ_8, CRE_SZ_16, CRE_SZ_32, CRE_SZ_64, CRE_SZ_128
   } cre_size_e;
   // Loop unit configuration decoded from the two mode bits.
   typedef enum logic [1:0] {
      CRE_MODE_EXTERNAL, CRE_MODE_INTERNAL, CRE_MODE_RESERVED
   } cre_mode_e;
   // Kinds of memory access that pass through address handling.
   typedef enum logic [1:0] {
      CRE_ACC_DATA, CRE_ACC_FETCH, CRE_ACC_PAGE_WALK, CRE_ACC_IO
   } cre_access_e;
   // One memory reference request from the core.
   typedef struct packed {
      logic valid;
      logic [31:0] base;
      logic [31:0] offset;
      cre_size_e size;
      cre_access_e kind;
      logic [63:0] wdata;
   } cre_mem_req_s;
   // One processed memory reference towards memory or the loop unit.
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic to_loop_unit;
      logic trap;
      logic [63:0] wdata;
   } cre_mem_out_s;
endpackage

// ---- sim/tb_top.sv ----
// Self-checking testbench for the control-register, byte-order and alignment block.
`timescale 1ns/10ps
module tb_top;
   // ****************************************************************
   // Stimulus and observation signals.
   // ****************************************************************
   logic core_clk;
   logic arst_n;
   logic status_user_level;
   logic big_endian_select;
   logic control_reg_load;
   logic control_reg_store;
   logic [3:0] ctrl_sel;
   logic [31:0] ctrl_wdata;
   logic [31:0] ctrl_rdata;
   logic loop_start;
   logic loop_start_nested;
   logic loop_to_serial;
   logic loop_idle;
   logic iter_advance;
   cre_pkg::cre_mem_req_s mem_req;
   cre_pkg::cre_mem_out_s mem_out;
   logic [63:0] load_swap_mask;
   int fails;
   int comparisons;
   // Lane maps: identity for little-endian, full reversal for a big-endian 64-bit item.
   localparam logic [63:0] LANE_LE = 64'h0706050403020100;
   localparam logic [63:0] LANE_BE64 = 64'h0001020304050607;
   // The design under test.
   cre_ctrl_endian_align #(.ITER_WIDTH(32)) dut_u (.core_clk(core_clk), .arst_n(arst_n),
      .status_user_level(status_user_level), .big_endian_select(big_endian_select),
      .control_reg_load(control_reg_load), .control_reg_store(control_reg_store),
      .ctrl_sel(ctrl_sel), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
      .loop_start(loop_start), .loop_start_nested(loop_start_nested),
      .loop_to_serial(loop_to_serial), .loop_idle(loop_idle), .iter_advance(iter_advance),
      .mem_req(mem_req), .mem_out(mem_out), .load_swap_mask(load_swap_mask));
   // Free-running 100 MHz clock.
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // ****************************************************************
   // Shared tasks.
   // ****************************************************************
   // Compares one value; the name says what was looked at.
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("comparisons %0d, fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // One control-register store, a single-cycle pulse launched on a falling edge.
   task automatic store(input logic [3:0] sel, input logic [31:0] val);
      ctrl_sel = sel;
      ctrl_wdata = val;
      control_reg_store = 1'b1;
      @(negedge core_clk);
      control_reg_store = 1'b0;
      // One idle cycle, so a following store never re-raises the strobe at once.
      @(negedge core_clk);
   endtask
   // Reads combinationally with the load strobe held high, then drops it.
   task automatic read_chk(input string what, input logic [3:0] sel, input logic [31:0] exp);
      ctrl_sel = sel;
      control_reg_load = 1'b1;
      #1;
      chk(what, ctrl_rdata, exp);
      @(negedge core_clk);
      control_reg_load = 1'b0;
      // One idle cycle, so the read port settles back to zero between reads.
      @(negedge core_clk);
   endtask
   // One memory reference; its processed form is judged one cycle later.
   task automatic mem_chk(input logic [31:0] b, input logic [31:0] o,
         input cre_pkg::cre_size_e sz, input cre_pkg::cre_access_e k,
         input logic [31:0] ea, input logic et, input logic eu, input logic [63:0] em);
      mem_req.valid = 1'b1;
      mem_req.base = b;
      mem_req.offset = o;
      mem_req.size = sz;
      mem_req.kind = k;
      mem_req.wdata = 64'h1122334455667788;
      @(negedge core_clk);
      mem_req.valid = 1'b0;
      chk("mem valid", mem_out.valid, 1'b1);
      chk("mem addr", mem_out.addr, ea);
      chk("mem trap", mem_out.trap, et);
      chk("mem to unit", mem_out.to_loop_unit, eu);
      chk("lane map", load_swap_mask, em);
      chk("mem wdata", mem_out.wdata, 64'h1122334455667788);
      // One idle cycle, so valid is never lowered and raised in one time step.
      @(negedge core_clk);
   endtask
   // Pulses one loop event input for a single cycle.
   task automatic pulse(input int which);
      if (which == 0) loop_start = 1'b1;
      if (which == 1) loop_to_serial = 1'b1;
      if (which == 2) iter_advance = 1'b1;
      @(negedge core_clk);
      loop_start = 1'b0;
      loop_to_serial = 1'b0;
      iter_advance = 1'b0;
   endtask
   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   // Reset values, then supervisor and user stores to every protected register.
   task automatic test_privilege();
      for (int s = 0; s < 7; s++) read_chk("reset value", s[3:0], 32'h0);
      chk("idle read data", ctrl_rdata, 32'h0);
      for (int s = 0; s < 5; s++) begin
         status_user_level = 1'b0;
         store(s[3:0], 32'h5a00_0000 | (s << 13));
         status_user_level = 1'b1;
         store(s[3:0], 32'hffff_ffff);
         read_chk("user read", s[3:0], 32'h5a00_0000 | (s << 13));
      end
      store(4'h7, 32'hdead_beef);
      read_chk("unmapped", 4'h7, 32'h0);
      read_chk("flags after scratch", cre_pkg::SEL_LOOP_CONDITION_FLAGS, 32'h0);
      status_user_level = 1'b0;
      $display("test_privilege done");
   endtask
   // Mode decode and the two-page loop unit window.
   task automatic test_window();
      store(cre_pkg::SEL_CONCURRENCY_CONFIG, 32'h8000_4003);
      read_chk("detached flag", cre_pkg::SEL_LOOP_CONDITION_FLAGS, 32'h4);
      mem_chk(32'h8000_5000, 32'hffc, cre_pkg::CRE_SZ_32, cre_pkg::CRE_ACC_DATA,
         32'h8000_5ffc, 1'b0, 1'b1, LANE_LE);
      mem_chk(32'h8000_4000, 32'h0, cre_pkg::CRE_SZ_8, cre_pkg::CRE_ACC_DATA,
         32'h8000_4000, 1'b0, 1'b1, LANE_LE);
      mem_chk(32'h8000_5fff, 32'h1, cre_pkg::CRE_SZ_8, cre_pkg::CRE_ACC_DATA,
         32'h8000_6000, 1'b0, 1'b0, LANE_LE);
      mem_chk(32'h8000_3ffc, 32'h0, cre_pkg::CRE_SZ_32, cre_pkg::CRE_ACC_DATA,
         32'h8000_3ffc, 1'b0, 1'b0, LANE_LE);
      mem_chk(32'h8000_4002, 32'h0, cre_pkg::CRE_SZ_32, cre_pkg::CRE_ACC_DATA,
         32'h8000_4002, 1'b1, 1'b0, LANE_LE);
      store(cre_pkg::SEL_CONCURRENCY_CONFIG, 32'h8000_4000);
      mem_chk(32'h8000_4000, 32'h0, cre_pkg::CRE_SZ_32, cre_pkg::CRE_ACC_DATA,
         32'h8000_4000, 1'b0, 1'b0, LANE_LE);
      read_chk("detached clear", cre_pkg::SEL_LOOP_CONDITION_FLAGS, 32'h0);
      store(cre_pkg::SEL_CONCURRENCY_CONFIG, 32'h8000_6003);
      mem_chk(32'h8000_4000, 32'h0, cre_pkg::CRE_SZ_32, cre_pkg::CRE_ACC_DATA,
         32'h8000_4000, 1'b0, 1'b0, LANE_LE);
      store(cre_pkg::SEL_CONCURRENCY_CONFIG, 32'h0);
      $display("test_window done");
   endtask
   // Loop flags and iteration counter wrap.
   task automatic test_loop();
      status_user_level = 1'b1;
      pulse(0);
      read_chk("in loop", cre_pkg::SEL_LOOP_CONDITION_FLAGS, 32'h1);
      loop_start_nested = 1'b1;
      pulse(0);
      read_chk("nested copy", cre_pkg::SEL_LOOP_CONDITION_FLAGS, 32'h3);
      pulse(1);
      read_chk("serial nested", cre_pkg::SEL_LOOP_CONDITION_FLAGS, 32'h3);
      loop_idle = 1'b1;
      pulse(1);
      read_chk("serial idle", cre_pkg::SEL_LOOP_CONDITION_FLAGS, 32'h2);
      loop_idle = 1'b0;
      loop_start_nested = 1'b0;
      store(cre_pkg::SEL_LOOP_CONDITION_FLAGS, 32'h1);
      read_chk("direct write", cre_pkg::SEL_LOOP_CONDITION_FLAGS, 32'h1);
      pulse(1);
      read_chk("serial plain", cre_pkg::SEL_LOOP_CONDITION_FLAGS, 32'h0);
      store(cre_pkg::SEL_LOOP_ITERATION_COUNT, 32'hffff_fffe);
      pulse(2);
      read_chk("count", cre_pkg::SEL_LOOP_ITERATION_COUNT, 32'hffff_ffff);
      pulse(2);
      read_chk("count wrap", cre_pkg::SEL_LOOP_ITERATION_COUNT, 32'h0);
      status_user_level = 1'b0;
      $display("test_loop done");
   endtask
   // Address wrap, byte order per access kind and alignment at 16, 32, 64 and 128 bits.
   task automatic test_memory();
      mem_chk(32'hffff_fffc, 32'h8, cre_pkg::CRE_SZ_32, cre_pkg::CRE_ACC_DATA,
         32'h4, 1'b0, 1'b0, LANE_LE);
      for (int a = 0; a < 16; a++) begin
         mem_chk(32'h100, a, cre_pkg::CRE_SZ_128, cre_pkg::CRE_ACC_DATA,
            32'h100 + a, a != 0, 1'b0, LANE_LE);
         mem_chk(32'h100, a, cre_pkg::CRE_SZ_64, cre_pkg::CRE_ACC_IO,
            32'h100 + a, (a % 8) != 0, 1'b0, LANE_LE);
         mem_chk(32'h100, a, cre_pkg::CRE_SZ_32, cre_pkg::CRE_ACC_DATA,
            32'h100 + a, (a % 4) != 0, 1'b0, LANE_LE);
         mem_chk(32'h100, a, cre_pkg::CRE_SZ_16, cre_pkg::CRE_ACC_DATA,
            32'h100 + a, (a % 2) != 0, 1'b0, LANE_LE);
      end
      // Big-endian data stays in its own 64-bit words, apart from the little-endian ones.
      big_endian_select = 1'b1;
      mem_chk(32'h300, 32'h4, cre_pkg::CRE_SZ_32, cre_pkg::CRE_ACC_DATA,
         32'h304, 1'b0, 1'b0, 64'h0405060700010203);
      mem_chk(32'h200, 32'h8, cre_pkg::CRE_SZ_64, cre_pkg::CRE_ACC_DATA,
         32'h208, 1'b0, 1'b0, LANE_BE64);
      mem_chk(32'h200, 32'h0, cre_pkg::CRE_SZ_64, cre_pkg::CRE_ACC_IO,
         32'h200, 1'b0, 1'b0, LANE_BE64);
      mem_chk(32'h200, 32'h0, cre_pkg::CRE_SZ_64, cre_pkg::CRE_ACC_FETCH,
         32'h200, 1'b0, 1'b0, LANE_LE);
      mem_chk(32'h200, 32'h4, cre_pkg::CRE_SZ_32, cre_pkg::CRE_ACC_PAGE_WALK,
         32'h204, 1'b0, 1'b0, LANE_LE);
      big_endian_select = 1'b0;
      $display("test_memory done");
   endtask
   // ****************************************************************
   // Main sequence and watchdog.
   // ****************************************************************
   initial begin
      fails = 0;
      comparisons = 0;
      arst_n = 1'b0;
      status_user_level = 1'b0;
      big_endian_select = 1'b0;
      control_reg_load = 1'b0;
      control_reg_store = 1'b0;
      ctrl_sel = 4'h0;
      ctrl_wdata = 32'h0;
      loop_start = 1'b0;
      loop_start_nested = 1'b0;
      loop_to_serial = 1'b0;
      loop_idle = 1'b0;
      iter_advance = 1'b0;
      mem_req = '0;
      repeat (20) @(negedge core_clk);
      arst_n = 1'b1;
      @(negedge core_clk);
      test_privilege();
      test_window();
      test_loop();
      test_memory();
      print_verdict();
   end
   // The tests need well under 1000 cycles; ten times that means a hang.
   initial begin
      #100000;
      fails++;
      $display("unexpected watchdog: expected end of tests, seen timeout");
      print_verdict();
   end
endmodule // tb_top
